// ===== src/sup_pkg.sv
// Constants shared by the supervisor and its serial port.
// Assumes a 100 MHz system clock that also serves as the watchdog timebase.
package sup_pkg;

  // Timebase
  localparam int CLK_KHZ      = 100000;
  localparam int WD_SHORT_MS  = 200;
  localparam int WD_MID_MS    = 600;
  localparam int WD_LONG_MS   = 1400;
  localparam int RST_HOLD_MS  = 200;
  localparam int NV_WRITE_US  = 10;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
  localparam int WD_MID_CYC   = WD_MID_MS * CLK_KHZ;
  localparam int WD_LONG_CYC  = WD_LONG_MS * CLK_KHZ;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int NV_WRITE_CYC = (NV_WRITE_US * CLK_KHZ) / 1000;

  // Counter widths
  localparam int CNT_W = 28;
  localparam int NV_W  = 10;

  // Period select codes, high bit then low bit
  localparam logic [1:0] PER_LONG   = 2'b00;
  localparam logic [1:0] PER_MID    = 2'b01;
  localparam logic [1:0] PER_SHORT  = 2'b10;
  localparam logic [1:0] PER_OFF    = 2'b11;
  localparam logic [1:0] PERIOD_RST = PER_LONG;

  // Watchdog register layout
  localparam int         SEL_HI_BIT = 4;
  localparam int         SEL_LO_BIT = 3;
  localparam logic [7:0] SET_MASK   = 8'hE7;
  localparam logic [7:0] RD_BUSY    = 8'hFF;

  // Serial opcodes
  localparam logic [7:0] OP_EN   = 8'h06;
  localparam logic [7:0] OP_DIS  = 8'h04;
  localparam logic [7:0] OP_SET  = 8'h01;
  localparam logic [7:0] OP_READ = 8'h05;

  // Supply trip level store
  localparam int         TRIP_W   = 8;
  localparam logic [7:0] TRIP_RST = 8'h00;

  // Position within a select-low frame
  typedef enum logic [1:0] {
    FR_OPC  = 2'b00,
    FR_DATA = 2'b01,
    FR_DONE = 2'b10,
    FR_OVER = 2'b11
  } frame_e;

endpackage

// ===== src/wd_link_if.sv
// Bytes between the serial-clock port and the system-clock controller.
// Assumes rx_byte is stable for a whole byte time after each rx_tgl flip.
`timescale 1ns/10ps
`default_nettype none
interface wd_link_if;
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic [7:0] tx_byte;

  modport ctrl (input rx_byte, input rx_tgl, output tx_byte);
  modport port (output rx_byte, output rx_tgl, input tx_byte);
endinterface
`default_nettype wire

// ===== src/serial_port.sv
// Mode 0 serial shifter running on the link clock.
// Assumes the link clock idles low and stops while select is high.
`timescale 1ns/10ps
`default_nettype none
module serial_port (
  // Link clock and pins
  input  wire logic sck,
  input  wire logic rst_n,
  input  wire logic cs_pin,
  input  wire logic si,
  output var  logic so_q,
  // Toward the controller
  wd_link_if.port   lnk
);
  import sup_pkg::*;

  typedef struct packed {
    logic [3:0] nbits;
    logic [7:0] sh;
    logic       rd_sel;
  } frm_s;

  typedef struct packed {
    logic [7:0] rx;
    logic       tgl;
    logic [7:0] rd_m;
    logic [7:0] rd_s;
  } hold_s;

  typedef struct packed {
    logic       so;
    logic [7:0] osh;
  } out_s;

  frm_s       f_q, f_d;
  hold_s      h_q, h_d;
  out_s       o_q, o_d;
  logic       clr;
  logic [7:0] in_byte;

  // Select high clears the frame; no edge arrives then, so the release is safe
  assign clr = cs_pin | ~rst_n;

  always_comb begin
    in_byte = {f_q.sh[6:0], si};
    f_d     = f_q;
    h_d     = h_q;
    o_d     = o_q;
    // R13 R14: rising edge sampling
    f_d.sh    = in_byte;
    f_d.nbits = f_q.nbits + 4'h1;
    if (f_q.nbits[2:0] == 3'h7) begin
      h_d.rx  = in_byte;
      h_d.tgl = ~h_q.tgl;
    end
    if (f_q.nbits == 4'h7) begin
      f_d.rd_sel = (in_byte == OP_READ);
    end
    // Status word is quasi-static; it settles during the opcode byte
    h_d.rd_m = lnk.tx_byte;
    h_d.rd_s = h_q.rd_m;
    // R12 R14: falling edge output
    if (f_q.nbits == 4'h8 && f_q.rd_sel) begin
      o_d.so  = h_q.rd_s[7];
      o_d.osh = {h_q.rd_s[6:0], 1'b0};
    end else begin
      o_d.so  = o_q.osh[7];
      o_d.osh = {o_q.osh[6:0], 1'b0};
    end
  end

  always_ff @(posedge sck or posedge clr) begin
    if (clr) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  always_ff @(negedge sck or posedge clr) begin
    if (clr) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign so_q        = o_q.so;
  assign lnk.rx_byte = h_q.rx;
  assign lnk.rx_tgl  = h_q.tgl;
endmodule
`default_nettype wire

// ===== src/supply_supervisor_watchdog.sv
// Supply supervisor: power-on and low-supply reset, watchdog, serial setup.
// Assumes the supply comparator and all pins are asynchronous to CLK.
//
// How it works
// R1: Watchdog offers 0.2, 0.6, 1.4 s or off.
// R2: Period choice kept in nonvolatile bits.
// R3: Two select bits pick the period.
// R4: Each select falling edge restarts the watchdog.
// R5: Select stuck past the period asserts reset.
// R6: Processor must kick before each period ends.
// R7: Reset is open-drain, low while supply low.
// R8: Reset held 200 ms after supply recovers.
// R9: Power-up reset held 200 ms after stabilizing.
// R10: Select high: output off, standby unless busy.
// R11: Host gives a select falling edge first.
// R12: Output bit changes on serial clock fall.
// R13: Input sampled on rising edge, MSB first.
// R14: Serial link runs in mode 0.
// R15: Trip level frozen while program enable low.
// R16: Codes 00/01/10/11 give 1.4/0.6/0.2 s/off.
// R17: Watchdog counts on internal timebase, clears on kick.
// R18: Synced supply flag restarts the release count.
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_watchdog #(
  parameter int WD_SHORT_LIM = sup_pkg::WD_SHORT_CYC,
  parameter int WD_MID_LIM   = sup_pkg::WD_MID_CYC,
  parameter int WD_LONG_LIM  = sup_pkg::WD_LONG_CYC,
  parameter int HOLD_LIM     = sup_pkg::RST_HOLD_CYC
) (
  // System clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  // Serial link
  input  wire logic                       SCK,
  input  wire logic                       SELECT_KICK_IN,
  input  wire logic                       SI,
  output var  logic                       SO_OUT,
  output var  logic                       SO_OE,
  // Supply monitor
  input  wire logic                       SUPPLY_LOW,
  input  wire logic                       TRIP_PROGRAM_ENABLE,
  input  wire logic [sup_pkg::TRIP_W-1:0] TRIP_LEVEL_IN,
  output var  logic [sup_pkg::TRIP_W-1:0] SUPPLY_TRIP_LEVEL,
  // Reset pin and power state
  output var  logic                       RESET_OUT,
  output var  logic                       RESET_OE,
  output var  logic                       STANDBY
);
  import sup_pkg::*;

  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic              cs_p;
    logic              sup_m;
    logic              sup_s;
    logic              tpe_m;
    logic              tpe_s;
    logic              tgl_m;
    logic              tgl_s;
    logic              tgl_p;
    logic [TRIP_W-1:0] trip_m;
    logic [TRIP_W-1:0] trip_s;
    logic [TRIP_W-1:0] trip;
    logic [1:0]        period;
    logic              latch;
    logic              armed;
    frame_e            frame;
    logic [7:0]        opc;
    logic [7:0]        wdata;
    logic              busy;
    logic [NV_W-1:0]   busy_cnt;
    logic [CNT_W-1:0]  wd_cnt;
    logic [CNT_W-1:0]  hold_cnt;
    logic              rst_oe;
    logic              rst_lvl;
    logic              so_oe;
    logic              standby;
    logic [7:0]        rd;
  } state_s;

  localparam state_s ST_RST = '{
    cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, sup_m: 1'b1, sup_s: 1'b1,
    tpe_m: 1'b0, tpe_s: 1'b0, tgl_m: 1'b0, tgl_s: 1'b0, tgl_p: 1'b0,
    trip_m: '0, trip_s: '0, trip: TRIP_RST, period: PERIOD_RST,
    latch: 1'b0, armed: 1'b0, frame: FR_OPC, opc: '0, wdata: '0,
    busy: 1'b0, busy_cnt: '0, wd_cnt: '0, hold_cnt: '0,
    rst_oe: 1'b1, rst_lvl: 1'b0, so_oe: 1'b0, standby: 1'b1, rd: '0
  };

  localparam logic [CNT_W-1:0] HOLD_END = CNT_W'(HOLD_LIM);
  localparam logic [NV_W-1:0]  NV_END   = NV_W'(NV_WRITE_CYC - 1);

  state_s           st_q, st_d;
  logic [CNT_W-1:0] wd_lim;
  logic             kick_fall;
  logic             cs_rise;
  logic             byte_evt;
  logic             wd_fire;

  wd_link_if lnk ();

  serial_port u_port (
    .sck    (SCK),
    .rst_n  (RST_N),
    .cs_pin (SELECT_KICK_IN),
    .si     (SI),
    .so_q   (SO_OUT),
    .lnk    (lnk.port)
  );

  assign lnk.tx_byte = st_q.rd;

  always_comb begin
    st_d      = st_q;
    wd_lim    = '0;
    wd_fire   = 1'b0;
    kick_fall = st_q.cs_p & ~st_q.cs_s;
    cs_rise   = ~st_q.cs_p & st_q.cs_s;
    byte_evt  = st_q.tgl_s ^ st_q.tgl_p;
    if (CE) begin
      // Pin synchronisers
      st_d.cs_m   = SELECT_KICK_IN;
      st_d.cs_s   = st_q.cs_m;
      st_d.cs_p   = st_q.cs_s;
      st_d.sup_m  = SUPPLY_LOW;
      st_d.sup_s  = st_q.sup_m;
      st_d.tpe_m  = TRIP_PROGRAM_ENABLE;
      st_d.tpe_s  = st_q.tpe_m;
      st_d.tgl_m  = lnk.rx_tgl;
      st_d.tgl_s  = st_q.tgl_m;
      st_d.tgl_p  = st_q.tgl_s;
      st_d.trip_m = TRIP_LEVEL_IN;
      st_d.trip_s = st_q.trip_m;

      // R1 R16: period decode
      case (st_q.period)
        PER_LONG:  wd_lim = CNT_W'(WD_LONG_LIM);
        PER_MID:   wd_lim = CNT_W'(WD_MID_LIM);
        PER_SHORT: wd_lim = CNT_W'(WD_SHORT_LIM);
        default:   wd_lim = '0;
      endcase

      // R4 R5 R17: kick clears, limit fires
      if (kick_fall || st_q.rst_oe || st_q.period == PER_OFF) begin
        st_d.wd_cnt = '0;
      end else if (st_q.wd_cnt == wd_lim) begin
        wd_fire     = 1'b1;
        st_d.wd_cnt = '0;
      end else begin
        st_d.wd_cnt = st_q.wd_cnt + 1'b1;
      end

      // R8 R9 R18: release delay restarts while low
      if (st_q.sup_s || wd_fire) begin
        st_d.hold_cnt = '0;
      end else if (st_q.hold_cnt != HOLD_END) begin
        st_d.hold_cnt = st_q.hold_cnt + 1'b1;
      end
      // R7: drive low while any cause stands
      st_d.rst_oe = st_q.sup_s | wd_fire | (st_q.hold_cnt != HOLD_END);

      // R15: trip level taken only when enabled
      if (st_q.tpe_s) begin
        st_d.trip = st_q.trip_s;
      end

      // Nonvolatile write time
      if (st_q.busy) begin
        if (st_q.busy_cnt == NV_END) begin
          st_d.busy = 1'b0;
        end else begin
          st_d.busy_cnt = st_q.busy_cnt + 1'b1;
        end
      end

      // R11: nothing accepted before the first select fall
      if (kick_fall) begin
        st_d.armed = 1'b1;
      end

      if (byte_evt && st_q.armed) begin
        case (st_q.frame)
          FR_OPC: begin
            st_d.opc   = lnk.rx_byte;
            st_d.frame = FR_DATA;
            if (lnk.rx_byte == OP_EN) begin
              st_d.latch = 1'b1;
            end else if (lnk.rx_byte == OP_DIS) begin
              st_d.latch = 1'b0;
            end
          end
          FR_DATA: begin
            st_d.wdata = lnk.rx_byte;
            st_d.frame = FR_DONE;
          end
          default: st_d.frame = FR_OVER;
        endcase
      end

      // A write takes effect only if select rises after exactly two bytes
      if (cs_rise) begin
        // R2 R3: commit period bits
        if (st_q.opc == OP_SET && st_d.frame == FR_DONE && st_d.latch && !st_q.busy
            && (st_d.wdata & SET_MASK) == 8'h00) begin
          st_d.period   = st_d.wdata[SEL_HI_BIT -: 2];
          st_d.latch    = 1'b0;
          st_d.busy     = 1'b1;
          st_d.busy_cnt = '0;
        end
        st_d.frame = FR_OPC;
      end

      // R10: deselect and standby
      st_d.so_oe   = ~st_q.cs_s;
      st_d.standby = st_q.cs_s & ~st_q.busy;

      st_d.rd = 8'h00;
      st_d.rd[SEL_HI_BIT] = st_q.period[1];
      st_d.rd[SEL_LO_BIT] = st_q.period[0];
      if (st_q.busy) begin
        st_d.rd = RD_BUSY;
      end
    end
  end

  // Period bits survive supply dips; only RST_N reloads them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign RESET_OUT         = st_q.rst_lvl;
  assign RESET_OE          = st_q.rst_oe;
  assign SO_OE             = st_q.so_oe;
  assign STANDBY           = st_q.standby;
  assign SUPPLY_TRIP_LEVEL = st_q.trip;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_low_rst;
    (CE && st_q.sup_s) |=> RESET_OE;
  endproperty
  a_low_rst: assert property (p_low_rst) // R7
    else $error("Reset released while supply low");

  property p_hold;
    (CE && !st_q.sup_s && st_q.hold_cnt != HOLD_END) |=> RESET_OE;
  endproperty
  a_hold: assert property (p_hold) // R8
    else $error("Reset released before the hold time ended");

  property p_restart;
    (CE && st_q.sup_s) |=> (st_q.hold_cnt == '0);
  endproperty
  a_restart: assert property (p_restart) // R18
    else $error("Release count not restarted by low supply");

  property p_kick;
    (CE && kick_fall) |=> (st_q.wd_cnt == '0);
  endproperty
  a_kick: assert property (p_kick) // R4
    else $error("Watchdog not restarted by select fall");

  property p_fire;
    (CE && !st_q.rst_oe && !kick_fall && st_q.period != PER_OFF && st_q.wd_cnt == wd_lim)
      |=> (RESET_OE && st_q.hold_cnt == '0);
  endproperty
  a_fire: assert property (p_fire) // R5
    else $error("Watchdog expiry did not assert reset");

  property p_off;
    (CE && st_q.period == PER_OFF) |=> (st_q.wd_cnt == '0);
  endproperty
  a_off: assert property (p_off) // R16
    else $error("Watchdog counting while disabled");

  property p_trip;
    (CE && !st_q.tpe_s) |=> $stable(SUPPLY_TRIP_LEVEL);
  endproperty
  a_trip: assert property (p_trip) // R15
    else $error("Trip level changed without program enable");

  property p_desel;
    (CE && st_q.cs_s) |=> (!SO_OE && STANDBY == !$past(st_q.busy));
  endproperty
  a_desel: assert property (p_desel) // R10
    else $error("Serial output driven while deselected");

  property p_arm;
    !st_q.armed |-> (st_q.frame == FR_OPC && !st_q.latch);
  endproperty
  a_arm: assert property (p_arm) // R11
    else $error("Serial activity taken before first select fall");

  property p_commit;
    !$stable(st_q.period) |-> ($past(cs_rise) && $past(st_q.opc) == OP_SET && st_q.busy);
  endproperty
  a_commit: assert property (p_commit) // R3
    else $error("Period bits changed without a valid write");
endmodule
`default_nettype wire

// ===== tb/spi_host_model.sv
// Host controller model: mode 0 serial master that also kicks the watchdog.
// Assumes callers leave the select line high between frames.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Pins toward the supervisor
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end

  task automatic shift(input logic [15:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 15; i > 15 - n; i--) begin
      si = d[i];
      #15 sck = 1'b1;
      rx = {rx[6:0], so_oe ? so_out : ~rx[0]};
      #15 sck = 1'b0;
    end
    // Released data line must not look held
    si = ~si;
  endtask

  task automatic frame(input logic [15:0] d, input int n, output logic [7:0] rx);
    #3 cs_n = 1'b0;
    #60;
    shift(d, n, rx);
    #60 cs_n = 1'b1;
    #60;
  endtask

  task automatic send8(input logic [7:0] op);
    logic [7:0] rx;
    frame({op, 8'h00}, 8, rx);
  endtask

  task automatic send16(input logic [15:0] d, output logic [7:0] rx);
    frame(d, 16, rx);
  endtask

  // select held low with no clocks
  task automatic hold_low(input int t);
    cs_n = 1'b0;
    #t cs_n = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

// ===== tb/supply_supervisor_watchdog_test.sv
// Self-checking bench for the supply supervisor with shortened counts.
// Assumes the host model drives the serial pins in its own time base.
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_watchdog_test;
  import sup_pkg::*;
  localparam int HOLD  = 200;
  localparam int LIM_S = 300;
  localparam int LIM_M = 500;
  localparam int LIM_L = 700;

  logic       CLK                 = 1'b0;
  logic       RST_N               = 1'b0;
  logic       CE                  = 1'b1;
  logic       SUPPLY_LOW          = 1'b0;
  logic       TRIP_PROGRAM_ENABLE = 1'b0;
  logic [7:0] TRIP_LEVEL_IN       = 8'h00;
  logic       sck, cs_n, si, SO_OUT, SO_OE, RESET_OUT, RESET_OE, STANDBY, rst_pin_n;
  logic [7:0] SUPPLY_TRIP_LEVEL, rx;
  int         n_errors = 0;
  int         compares = 0;

  always #5 CLK = ~CLK;
  // Open-drain pin with pull-up
  assign rst_pin_n = RESET_OE ? RESET_OUT : 1'b1;

  supply_supervisor_watchdog #(
    .WD_SHORT_LIM(LIM_S), .WD_MID_LIM(LIM_M), .WD_LONG_LIM(LIM_L), .HOLD_LIM(HOLD)
  ) dut (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .SCK(sck), .SELECT_KICK_IN(cs_n), .SI(si),
    .SO_OUT(SO_OUT), .SO_OE(SO_OE), .SUPPLY_LOW(SUPPLY_LOW),
    .TRIP_PROGRAM_ENABLE(TRIP_PROGRAM_ENABLE), .TRIP_LEVEL_IN(TRIP_LEVEL_IN),
    .SUPPLY_TRIP_LEVEL(SUPPLY_TRIP_LEVEL), .RESET_OUT(RESET_OUT), .RESET_OE(RESET_OE), .STANDBY(STANDBY)
  );
  spi_host_model mcu (.sck(sck), .cs_n(cs_n), .si(si), .so_out(SO_OUT), .so_oe(SO_OE));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int n, input int lo, input int hi);
    compares++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, n);
    end
  endtask

  // Capped so a stuck pin cannot hang the run
  task automatic wait_pin(input logic v, output int n);
    n = 0;
    while (rst_pin_n !== v && n < 3000) begin
      @(negedge CLK);
      n++;
    end
  endtask

  task automatic kick;
    mcu.frame(16'h0000, 0, rx);
  endtask

  task automatic give_verdict;
    $display("compares %0d, n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_por;
    int n;
    repeat (10) @(negedge CLK);
    chk("reset pin", 8'h00, 8'(rst_pin_n));
    chk("standby", 8'h01, 8'(STANDBY));
    chk("output enable", 8'h00, 8'(SO_OE));
    @(posedge CLK) RST_N <= 1'b1;
    wait_pin(1'b1, n);
    rng("power-up hold", n, HOLD, HOLD + 7);
    $display("test power-up done");
  endtask

  task automatic t_trip;
    mcu.send16({OP_READ, 8'h00}, rx);
    chk("default period", 8'({PERIOD_RST, 3'b000}), rx);
    @(posedge CLK) TRIP_LEVEL_IN <= 8'hA5;
    repeat (8) @(negedge CLK);
    chk("frozen trip", TRIP_RST, SUPPLY_TRIP_LEVEL);
    @(posedge CLK) TRIP_PROGRAM_ENABLE <= 1'b1;
    repeat (8) @(negedge CLK);
    chk("updated trip", 8'hA5, SUPPLY_TRIP_LEVEL);
    @(posedge CLK) TRIP_PROGRAM_ENABLE <= 1'b0;
    @(posedge CLK) TRIP_LEVEL_IN <= 8'h3C;
    repeat (8) @(negedge CLK);
    chk("held trip", 8'hA5, SUPPLY_TRIP_LEVEL);
    $display("test trip level done");
  endtask

  task automatic t_brownout;
    int n;
    kick();
    @(posedge CLK) SUPPLY_LOW <= 1'b1;
    wait_pin(1'b0, n);
    rng("low assert", n, 1, 4);
    @(posedge CLK) SUPPLY_LOW <= 1'b0;
    repeat (100) @(posedge CLK);
    // Short dip must restart the hold
    SUPPLY_LOW <= 1'b1;
    repeat (3) @(posedge CLK);
    SUPPLY_LOW <= 1'b0;
    wait_pin(1'b1, n);
    rng("low release", n, HOLD, HOLD + 7);
    $display("test brownout done");
  endtask

  task automatic t_period(input logic [1:0] code, input int lim);
    int n;
    int drops;
    logic [7:0] dat;
    dat = {3'b000, code, 3'b000};
    drops = 0;
    mcu.send8(OP_EN);
    mcu.send16({OP_SET, dat}, rx);
    mcu.send16({OP_READ, 8'h00}, rx);
    chk("busy read", RD_BUSY, rx);
    chk("standby busy", 8'h00, 8'(STANDBY));
    repeat (5) begin
      kick();
      repeat (230) @(negedge CLK) drops += int'(rst_pin_n !== 1'b1);
    end
    chk("standby idle", 8'h01, 8'(STANDBY));
    chk("output released", 8'h00, 8'(SO_OE));
    mcu.send16({OP_READ, 8'h00}, rx);
    chk("period bits", dat, rx);
    if (lim == 0) begin
      repeat (LIM_L + 100) @(negedge CLK) drops += int'(rst_pin_n !== 1'b1);
    end else if (code[1]) begin
      fork
        mcu.hold_low(10 * (lim + 60));
        wait_pin(1'b0, n);
      join
      rng("stuck low", n, lim, lim + 9);
      wait_pin(1'b1, n);
    end else begin
      kick();
      wait_pin(1'b0, n);
      rng("stuck high", n, lim - 20, lim - 8);
      wait_pin(1'b1, n);
      rng("watchdog hold", n, HOLD - 2, HOLD + 6);
    end
    rng("kicked drops", drops, 0, 0);
    $display("test period %b done", code);
  endtask

  task automatic t_refused;
    mcu.send16({OP_SET, 8'h00}, rx);
    repeat (20) @(negedge CLK);
    mcu.send16({OP_READ, 8'h00}, rx);
    chk("unlatched write", 8'h18, rx);
    $display("test refused write done");
  endtask

  task automatic t_freeze;
    int n;
    @(posedge CLK) begin
      CE         <= 1'b0;
      SUPPLY_LOW <= 1'b1;
    end
    repeat (20) @(negedge CLK);
    chk("frozen reset pin", 8'h01, 8'(rst_pin_n));
    @(posedge CLK) CE <= 1'b1;
    wait_pin(1'b0, n);
    rng("thawed assert", n, 1, 4);
    @(posedge CLK) SUPPLY_LOW <= 1'b0;
    wait_pin(1'b1, n);
    rng("dip release", n, HOLD, HOLD + 7);
    // Nonvolatile choice must outlive the supply dip
    mcu.send16({OP_READ, 8'h00}, rx);
    chk("period after dip", 8'h18, rx);
    $display("test clock enable and dip done");
  endtask

  initial begin
    t_por();
    t_trip();
    t_brownout();
    t_period(2'b00, LIM_L);
    t_period(2'b01, LIM_M);
    t_period(2'b10, LIM_S);
    t_period(2'b11, 0);
    t_refused();
    t_freeze();
    give_verdict();
  end

  // Whole run needs about 10000 cycles
  initial begin
    repeat (40000) @(posedge CLK);
    n_errors++;
    $display("unexpected run time: expected end, seen timeout");
    give_verdict();
  end
endmodule
`default_nettype wire
